// ---- shared/iocsp_pkg.sv ----
package iocsp_pkg;

    // APB register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Direction codes held in the configuration register
    localparam logic [1:0] DIR_INPUT = 2'h0;
    localparam logic [1:0] DIR_OUTPUT = 2'h1;
    localparam logic [1:0] DIR_BIDIR = 2'h2;

    // Configuration register field positions
    localparam int CFG_W = 14;
    localparam int CFG_DIR_LSB = 0;
    localparam int CFG_IN_USE_REG = 2;
    localparam int CFG_IN_LATCH = 3;
    localparam int CFG_IN_INIT_SET = 4;
    localparam int CFG_OUT_INIT_SET = 5;
    localparam int CFG_IN_CLK_INV = 6;
    localparam int CFG_OUT_CLK_INV = 7;
    localparam int CFG_OUT_INVERT = 8;
    localparam int CFG_OUT_USE_FF = 9;
    localparam int CFG_FAST_CAPTURE = 10;
    localparam int CFG_IN_CE_CONN = 11;
    localparam int CFG_OUT_CE_CONN = 12;
    localparam int CFG_TS_CONN = 13;
    localparam logic [13:0] CFG_RESET = 14'h0000;

    // Status register field positions
    localparam int STAT_PIN = 0;
    localparam int STAT_CAPTURE = 1;
    localparam int STAT_IN_Q = 2;
    localparam int STAT_OUT_Q = 3;
    localparam int STAT_OE = 4;

endpackage : iocsp_pkg

// ---- design/iocsp_top.sv ----
// What this block does
// - One cell serves one pin; configurable as input, output or bidirectional.
// - Pin signal goes straight to the direct taps or through the input register.
// - Input register is a flip-flop or a level latch, chosen by configuration.
// - Power-up or global_init forces both registers to their set/reset value.
// - Flip-flop mode captures on rising clock edge, after inversion, while enabled.
// - Latch mode without fast capture passes data while clock low and enabled, holds while high.
// - Enable low holds the input register; unconnected enable reads as high.
// - Fast capture latch is clocked by the output flip-flop clock.
// - Fast captured data is re-registered by the input flip-flop or latch.
// - Capture latch open while low; feeds rising-edge flop or open-high latch.
// - Every storage clock of the cell may be inverted inside the cell.
// - Output optionally inverted, then direct or through edge-triggered flip-flop.
// - Output flop loads on active edge when enabled; else holds its value.
// - Three-state high floats the driver; unconnected three-state reads as low.
`timescale 1ns/1ps

module iocsp_top
    import iocsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    input wire logic global_init_i,
    input wire logic in_storage_clock_i,
    input wire logic in_storage_clock_enable_i,
    input wire logic out_storage_clock_i,
    input wire logic out_storage_clock_enable_i,
    input wire logic out_data_i,
    input wire logic tristate_i,
    output logic direct_input_tap_a_o,
    output logic direct_input_tap_b_o,
    output logic in_reg_q_o
);

    typedef struct packed {
        logic [13:0] cfg;
        logic in_clk_prev;
        logic out_clk_prev;
        logic cap_q;
        logic in_q;
        logic out_q;
        logic pin_out;
        logic pin_oe;
        logic tap_a;
        logic tap_b;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iocsp_state_t;

    iocsp_state_t st;
    iocsp_state_t next_st;

    logic [1:0] dir;
    logic in_enabled;
    logic out_enabled;
    logic in_clk;
    logic out_clk;
    logic in_rise;
    logic out_rise;
    logic in_ce;
    logic out_ce;
    logic ts;
    logic in_d;
    logic latch_open;
    logic out_d;
    logic drive_val;
    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_stat;
    logic [31:0] status_word;
    logic [31:0] cfg_word;

    assign dir = st.cfg[CFG_DIR_LSB +: 2];

    // Direction code 3 leaves the cell unused: no taps, no driver
    always_comb begin
        in_enabled = 1'b0;
        out_enabled = 1'b0;
        case (dir)
            DIR_INPUT: begin
                in_enabled = 1'b1;
            end
            DIR_OUTPUT: begin
                out_enabled = 1'b1;
            end
            DIR_BIDIR: begin
                in_enabled = 1'b1;
                out_enabled = 1'b1;
            end
            default: begin
                in_enabled = 1'b0;
                out_enabled = 1'b0;
            end
        endcase
    end

    // Clock levels after the optional in-cell inversion
    always_comb begin
        in_clk = in_storage_clock_i;
        out_clk = out_storage_clock_i;
        if (st.cfg[CFG_IN_CLK_INV]) begin
            in_clk = !in_storage_clock_i;
        end
        if (st.cfg[CFG_OUT_CLK_INV]) begin
            out_clk = !out_storage_clock_i;
        end
    end

    // Storage clocks are sampled levels: a pulse shorter than one clk_i period may be lost.
    // Flipping an inversion bit can look like an edge, so pulse global_init after it.
    assign in_rise = in_clk && !st.in_clk_prev;
    assign out_rise = out_clk && !st.out_clk_prev;

    // Unconnected enables count as high, unconnected three-state as low
    always_comb begin
        in_ce = 1'b1;
        out_ce = 1'b1;
        ts = 1'b0;
        if (st.cfg[CFG_IN_CE_CONN]) begin
            in_ce = in_storage_clock_enable_i;
        end
        if (st.cfg[CFG_OUT_CE_CONN]) begin
            out_ce = out_storage_clock_enable_i;
        end
        if (st.cfg[CFG_TS_CONN]) begin
            ts = tristate_i;
        end
    end

    // Register input is the pin, or the fast capture latch re-registered here.
    // Plain latch opens on low clock; behind the capture latch it opens on high.
    always_comb begin
        if (st.cfg[CFG_FAST_CAPTURE]) begin
            in_d = st.cap_q;
            latch_open = in_clk;
        end else begin
            in_d = pin_i;
            latch_open = !in_clk;
        end
    end

    // Inversion applies ahead of both output routes
    always_comb begin
        out_d = out_data_i;
        if (st.cfg[CFG_OUT_INVERT]) begin
            out_d = !out_data_i;
        end
        if (st.cfg[CFG_OUT_USE_FF]) begin
            drive_val = st.out_q;
        end else begin
            drive_val = out_d;
        end
    end

    // APB decode; unmapped addresses hit nothing and answer with an error
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && st.pready;
    always_comb begin
        hit_cfg = 1'b0;
        hit_stat = 1'b0;
        case (paddr_i)
            CFG_OFFSET: begin
                hit_cfg = 1'b1;
            end
            STATUS_OFFSET: begin
                hit_stat = 1'b1;
            end
            default: begin
                hit_cfg = 1'b0;
                hit_stat = 1'b0;
            end
        endcase
    end

    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[CFG_W-1:0] = st.cfg;
        status_word = 32'h0000_0000;
        status_word[STAT_PIN] = pin_i;
        status_word[STAT_CAPTURE] = st.cap_q;
        status_word[STAT_IN_Q] = st.in_q;
        status_word[STAT_OUT_Q] = st.out_q;
        status_word[STAT_OE] = st.pin_oe;
    end

    always_comb begin
        next_st = st;

        // Register bus: answer in the cycle after setup, zero wait states
        next_st.pready = setup;
        next_st.pslverr = setup && !(hit_cfg || hit_stat);
        next_st.prdata = 32'h0000_0000;
        if (setup && !pwrite_i) begin
            if (hit_cfg) begin
                next_st.prdata = cfg_word;
            end else if (hit_stat) begin
                next_st.prdata = status_word;
            end
        end
        if (access && pwrite_i && hit_cfg) begin
            if (pstrb_i[0]) begin
                next_st.cfg[7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
                next_st.cfg[CFG_W-1:8] = pwdata_i[CFG_W-1:8];
            end
        end

        next_st.in_clk_prev = in_clk;
        next_st.out_clk_prev = out_clk;

        // Fast capture latch follows the pin while the output clock is low
        if (!out_clk) begin
            next_st.cap_q = pin_i;
        end

        // Input storage register
        if (st.cfg[CFG_IN_LATCH]) begin
            if (latch_open && in_ce) begin
                next_st.in_q = in_d;
            end
        end else begin
            if (in_rise && in_ce) begin
                next_st.in_q = in_d;
            end
        end

        // Output flip-flop, edge triggered only
        if (out_rise && out_ce) begin
            next_st.out_q = out_d;
        end

        // Initialisation overrides any clocked load
        if (global_init_i) begin
            next_st.cap_q = 1'b0;
            next_st.in_q = st.cfg[CFG_IN_INIT_SET];
            next_st.out_q = st.cfg[CFG_OUT_INIT_SET];
        end

        // Input taps: direct pin or stored value
        if (in_enabled) begin
            if (st.cfg[CFG_IN_USE_REG]) begin
                next_st.tap_a = st.in_q;
                next_st.tap_b = st.in_q;
            end else begin
                next_st.tap_a = pin_i;
                next_st.tap_b = pin_i;
            end
        end else begin
            next_st.tap_a = 1'b0;
            next_st.tap_b = 1'b0;
        end

        // Driver: same three-state gating on either output route
        next_st.pin_out = drive_val;
        next_st.pin_oe = 1'b0;
        if (out_enabled && !ts) begin
            next_st.pin_oe = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st.cfg <= CFG_RESET;
            st.in_clk_prev <= 1'b0;
            st.out_clk_prev <= 1'b0;
            st.cap_q <= 1'b0;
            st.in_q <= 1'b0;
            st.out_q <= 1'b0;
            st.pin_out <= 1'b0;
            st.pin_oe <= 1'b0;
            st.tap_a <= 1'b0;
            st.tap_b <= 1'b0;
            st.prdata <= 32'h0000_0000;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign pin_o = st.pin_out;
    assign pin_oe_o = st.pin_oe;
    assign direct_input_tap_a_o = st.tap_a;
    assign direct_input_tap_b_o = st.tap_b;
    assign in_reg_q_o = st.in_q;

endmodule : iocsp_top

// ---- verif/iocsp_chk.sv ----
`timescale 1ns/1ps
module iocsp_chk
    import iocsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pin_i,
    input wire logic pin_o,
    input wire logic pin_oe_o,
    input wire logic global_init_i,
    input wire logic in_storage_clock_i,
    input wire logic out_data_i,
    input wire logic tristate_i,
    input wire logic direct_input_tap_a_o,
    input wire logic direct_input_tap_b_o,
    input wire logic in_reg_q_o
);
    logic [13:0] cfg;
    logic [1:0] dir;
    assign dir = cfg[1:0];
    // Shadow of the configuration word, full-word writes only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg <= CFG_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == CFG_OFFSET) begin
            cfg <= pwdata_i[13:0];
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        pready_o ##1 !pready_o;
    endsequence
    a_ready_pulse: assert property (s_setup |=> s_access)
        else $error("pready not one pulse");
    a_taps_same: assert property (direct_input_tap_a_o == direct_input_tap_b_o)
        else $error("taps differ");
    a_tap_direct: assert property ((dir == DIR_INPUT || dir == DIR_BIDIR) && !cfg[2]
        |=> direct_input_tap_a_o == $past(pin_i)) else $error("tap not pin");
    a_oe_three: assert property (dir == DIR_OUTPUT && cfg[13]
        |=> pin_oe_o != $past(tristate_i)) else $error("oe wrong");
    a_out_direct: assert property (dir == DIR_OUTPUT && !cfg[9] && cfg[8]
        |=> pin_o != $past(out_data_i)) else $error("pin_o not inverted");
    a_init_in: assert property (global_init_i |=> in_reg_q_o == $past(cfg[4]))
        else $error("init value wrong");
    a_ff_load: assert property (cfg[11:9] == 3'h0 && cfg[6:3] == 4'h0 && !global_init_i
        && $rose(in_storage_clock_i) |=> in_reg_q_o == $past(pin_i)) else $error("no load");
    a_latch_hold: assert property (cfg[3] && !cfg[10] && !cfg[6] && in_storage_clock_i
        && !global_init_i |=> $stable(in_reg_q_o)) else $error("latch not held");
endmodule : iocsp_chk
bind iocsp_top iocsp_chk iocsp_chk_inst (.*);

// ---- verif/iocsp_pin_model.sv ----
`timescale 1ns/1ps
module iocsp_pin_model (
    input wire logic drv_i,
    input wire logic drv_en_i,
    input wire logic ext_i,
    output logic lvl_o
);
    // Board side drives the pin whenever the cell does not
    assign lvl_o = drv_en_i ? drv_i : ext_i;
endmodule : iocsp_pin_model

// ---- verif/iocsp_test.sv ----
`timescale 1ns/1ps
module iocsp_test;
    import iocsp_pkg::*;
    // rnd: 0 in clk, 1 in en, 2 out clk, 3 out en, 4 out data, 5 tristate, 6 board level
    logic [6:0] rnd = 7'h00;
    logic clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic gi = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, pin_i, pin_o, pin_oe_o, tap_a, tap_b, in_q, er;
    int mismatches = 0, num_checks = 0, chk = 0, ta, tb;
    int m_cfg, m_inq, m_outq, m_cap, m_tap, m_oe, m_po, m_ick, m_ock;
    int cfgs[10] = '{14'h3800, 14'h0856, 14'h080C, 14'h0C84, 14'h0C0C, 14'h2101, 14'h32A1,
        14'h0206, 14'h3C5E, 14'h0003};
    iocsp_top iocsp_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .global_init_i(gi),
        .in_storage_clock_i(rnd[0]),
        .in_storage_clock_enable_i(rnd[1]), .out_storage_clock_i(rnd[2]),
        .out_storage_clock_enable_i(rnd[3]), .out_data_i(rnd[4]), .tristate_i(rnd[5]),
        .direct_input_tap_a_o(tap_a), .direct_input_tap_b_o(tap_b), .in_reg_q_o(in_q));
    iocsp_pin_model iocsp_pin_model_inst (.drv_i(pin_o), .drv_en_i(pin_oe_o), .ext_i(rnd[6]),
        .lvl_o(pin_i));
    always #4 clk_i = !clk_i;
    task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (x !== g) begin
            mismatches++;
            $display("CHECK FAILED %s exp %0h got %0h", s, x, g);
        end
    endtask : cmp
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        // Idle edge first, so back-to-back calls never rewrite psel in one time step
        @(posedge clk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // Reference cell, stepped on the same edges as the design
    always @(posedge clk_i) begin
        ta = rnd[0] ^ m_cfg[6];
        tb = rnd[2] ^ m_cfg[7];
        m_tap <= (m_cfg[1:0] == DIR_INPUT || m_cfg[1:0] == DIR_BIDIR) ?
            (m_cfg[2] ? m_inq : pin_i) : 0;
        m_oe <= (m_cfg[1:0] == DIR_OUTPUT || m_cfg[1:0] == DIR_BIDIR) && !(m_cfg[13] && rnd[5]);
        m_po <= m_cfg[9] ? m_outq : rnd[4] ^ m_cfg[8];
        if (gi) begin
            m_inq <= m_cfg[4];
            m_outq <= m_cfg[5];
            m_cap <= 0;
        end else begin
            if (!tb) m_cap <= pin_i;
            if (tb && !m_ock && (rnd[3] || !m_cfg[12])) m_outq <= rnd[4] ^ m_cfg[8];
            if ((rnd[1] || !m_cfg[11]) && (m_cfg[3] ? ta == m_cfg[10] : ta && !m_ick))
                m_inq <= m_cfg[10] ? m_cap : pin_i;
        end
        m_ick <= ta;
        m_ock <= tb;
    end
    always @(negedge clk_i) begin
        if (chk) begin
            cmp("tap_a", m_tap, tap_a);
            cmp("tap_b", m_tap, tap_b);
            cmp("in_q", m_inq, in_q);
            cmp("pin_oe", m_oe, pin_oe_o);
            if (m_cfg[1:0] != DIR_INPUT) cmp("pin_o", m_po, pin_o);
        end
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        void'($urandom(90));
        foreach (cfgs[i]) begin
            chk = 0;
            resetn_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            resetn_i <= 1'b1;
            @(posedge clk_i);
            apb(CFG_OFFSET, 1'b1, cfgs[i]);
            m_cfg <= cfgs[i];
            apb(CFG_OFFSET, 1'b0, 32'h0);
            cmp("cfg", cfgs[i], rd);
            gi <= 1'b1;
            @(posedge clk_i);
            gi <= 1'b0;
            @(posedge clk_i);
            chk = 1;
            repeat (60) begin
                rnd <= 7'($urandom);
                gi <= $urandom % 9 == 0;
                @(posedge clk_i);
            end
            // Freeze the stimulus so the status snapshot has settled
            gi <= 1'b0;
            repeat (4) @(posedge clk_i);
            apb(STATUS_OFFSET, 1'b0, 32'h0);
            cmp("status", {27'h0, m_oe[0], m_outq[0], m_inq[0], m_cap[0], pin_i}, rd);
            $display("cfg %h done", cfgs[i]);
        end
        apb(12'hFF0, 1'b0, 32'h0);
        cmp("pslverr", 1, er);
        cmp("prdata", 0, rd);
        $display("bus error test done");
        report_and_stop;
    end
endmodule : iocsp_test
